// *** hw/csfa_cfg.svh ***
// Constants for the status flag and arithmetic block
// Behaviour
// - Reset forces interrupt mask flag to 1; other flags are undefined.
// - With base-ten flag set, add and subtract give packed decimal results.
// - In decimal mode the negative, overflow and zero flags are invalid.
// - Multiply and divide ignore index-X flag and base-ten flag.
// - Multiply and divide leave the whole status word unchanged.
// - Written interrupt request bits become visible one instruction later.
// - Instruction time is cycle count times internal clock; high speed is osc/2.
// - After reset the internal clock runs middle speed, osc/8.
`ifndef CSFA_CFG_SVH
`define CSFA_CFG_SVH
// ****************************************
// Status word bit positions
// ****************************************
`define CSFA_BIT_C 0
`define CSFA_BIT_Z 1
`define CSFA_BIT_I 2
`define CSFA_BIT_D 3
`define CSFA_BIT_B 4
`define CSFA_BIT_T 5
`define CSFA_BIT_V 6
`define CSFA_BIT_N 7
// ****************************************
// Clock division
// ****************************************
`define CSFA_DIV_MID 4'h8
`define CSFA_DIV_HIGH 4'h2
`define CSFA_DIV_ONE 4'h1
`define CSFA_DIV_ZERO 4'h0
// ****************************************
// Arithmetic constants
// ****************************************
`define CSFA_BCD_NINE 5'h09
`define CSFA_BCD_ADJ 4'h6
`define CSFA_DIV0_QUOT 8'hFF
// ****************************************
// Reset values
// ****************************************
`define CSFA_MASK_RST 1'b1
`define CSFA_BYTE_RST 8'h00
`define CSFA_IREQ_W 8
`endif

// *** hw/csfa_pkg.sv ***
// Types for the status flag and arithmetic block
package csfa_pkg;
    typedef enum logic [6:0]
    {
        CSFA_OP_NONE = 7'h01,
        CSFA_OP_ADD = 7'h02,
        CSFA_OP_SUB = 7'h04,
        CSFA_OP_MUL = 7'h08,
        CSFA_OP_DIV = 7'h10,
        CSFA_OP_SETC = 7'h20,
        CSFA_OP_CLRC = 7'h40
    } csfa_op_type;
    typedef enum logic [1:0]
    {
        CSFA_SPD_MID = 2'h1,
        CSFA_SPD_HIGH = 2'h2
    } csfa_speed_type;
endpackage

// *** hw/csfa_nibble.sv ***
// One decimal or binary digit slice of the adder
`timescale 1ns/1ns
`include "csfa_cfg.svh"
module csfa_nibble
(
    // Operands
    input wire logic [3:0] a,
    input wire logic [3:0] b,
    input wire logic cin,
    input wire logic sub,
    input wire logic dec,
    // Result
    output logic [3:0] sum,
    output logic cout
);
    logic [4:0] raw;
    always_comb
    begin
        if (sub)
        begin
            raw = {1'b0, a} - {1'b0, b} - {4'h0, ~cin};
            cout = ~raw[4];
            sum = raw[3:0];
            // Decimal borrow adjust
            if (dec && raw[4])
            begin
                sum = raw[3:0] - `CSFA_BCD_ADJ;
            end
        end
        else
        begin
            raw = {1'b0, a} + {1'b0, b} + {4'h0, cin};
            cout = raw[4];
            sum = raw[3:0];
            // Decimal carry adjust
            if (dec && (raw > `CSFA_BCD_NINE))
            begin
                sum = raw[3:0] + `CSFA_BCD_ADJ;
                cout = 1'b1;
            end
        end
    end
endmodule

// *** hw/csfa_core.sv ***
// Status word, arithmetic, request latency and internal clock divider
`timescale 1ns/1ns
`include "csfa_cfg.svh"
module csfa_core
    import csfa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Main oscillator pin, sampled
    input wire logic main_osc_input,
    // Instruction issue
    input wire logic op_valid,
    input wire csfa_op_type op_code,
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    // Status word writes
    input wire logic flags_we,
    input wire logic [7:0] flags_wdata,
    // Interrupt request writes
    input wire logic ireq_we,
    input wire logic [7:0] ireq_wdata,
    input wire logic [7:0] ireq_set,
    // Speed select
    input wire logic high_speed,
    // Results
    output logic [7:0] result_r,
    output logic [7:0] result_hi_r,
    output logic [7:0] cpu_flags_word,
    output logic [7:0] ireq_view_r,
    output logic phi_tick_r,
    output logic osc_seen_r
);
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic mask_r;
    logic [7:0] rest_r;
    logic [7:0] ireq_r;
    logic [7:0] ireq_pend_r;
    logic ireq_pend_v_r;
    logic [7:0] sum8;
    logic c_mid;
    logic c_out;
    logic is_sub;
    logic dec_on;
    logic [15:0] prod;
    logic [7:0] quot;
    logic [7:0] remd;
    logic [3:0] div_cnt_r;
    logic [3:0] div_lim;
    logic osc_s1_r;
    logic osc_s2_r;
    csfa_speed_type speed_r;
    // ****************************************
    // Adder made of two digit slices
    // ****************************************
    assign is_sub = (op_code == CSFA_OP_SUB);
    assign dec_on = flags_r[`CSFA_BIT_D];
    csfa_nibble u_lo
    (
        .a(op_a[3:0]),
        .b(op_b[3:0]),
        .cin(flags_r[`CSFA_BIT_C]),
        .sub(is_sub),
        .dec(dec_on),
        .sum(sum8[3:0]),
        .cout(c_mid)
    );
    csfa_nibble u_hi
    (
        .a(op_a[7:4]),
        .b(op_b[7:4]),
        .cin(c_mid),
        .sub(is_sub),
        .dec(dec_on),
        .sum(sum8[7:4]),
        .cout(c_out)
    );
    // Mode flags deliberately not consulted here
    assign prod = op_a * op_b;
    assign quot = (op_b == 8'h00) ? `CSFA_DIV0_QUOT : op_a / op_b;
    assign remd = (op_b == 8'h00) ? op_a : op_a % op_b;
    // ****************************************
    // Status word next value
    // ****************************************
    always_comb
    begin
        flags_nxt = flags_r;
        if (flags_we)
        begin
            flags_nxt = flags_wdata;
        end
        else if (op_valid)
        begin
            case (op_code)
                CSFA_OP_ADD, CSFA_OP_SUB:
                begin
                    flags_nxt[`CSFA_BIT_C] = c_out;
                    // N, V, Z still follow the binary view; meaningless in decimal
                    flags_nxt[`CSFA_BIT_N] = sum8[7];
                    flags_nxt[`CSFA_BIT_Z] = (sum8 == 8'h00);
                    flags_nxt[`CSFA_BIT_V] = is_sub
                        ? ((op_a[7] ^ op_b[7]) & (op_a[7] ^ sum8[7]))
                        : (~(op_a[7] ^ op_b[7]) & (op_a[7] ^ sum8[7]));
                end
                CSFA_OP_SETC:
                begin
                    flags_nxt[`CSFA_BIT_C] = 1'b1;
                end
                CSFA_OP_CLRC:
                begin
                    flags_nxt[`CSFA_BIT_C] = 1'b0;
                end
                // Multiply and divide touch no flag
                default:
                begin
                    flags_nxt = flags_r;
                end
            endcase
        end
    end
    // Only I has a reset value; the mask flop is kept apart so each flop has one process
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mask_r <= `CSFA_MASK_RST;
        end
        else
        begin
            mask_r <= flags_nxt[`CSFA_BIT_I];
        end
    end
    // Unreset flops: software must set these flags before relying on them
    always_ff @(posedge clk)
    begin
        rest_r <= flags_nxt;
    end
    always_comb
    begin
        flags_r = rest_r;
        flags_r[`CSFA_BIT_I] = mask_r;
    end
    assign cpu_flags_word = flags_r;
    // ****************************************
    // Results
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            result_r <= `CSFA_BYTE_RST;
            result_hi_r <= `CSFA_BYTE_RST;
        end
        else if (op_valid)
        begin
            case (op_code)
                CSFA_OP_ADD, CSFA_OP_SUB:
                begin
                    result_r <= sum8;
                end
                CSFA_OP_MUL:
                begin
                    result_r <= prod[7:0];
                    result_hi_r <= prod[15:8];
                end
                CSFA_OP_DIV:
                begin
                    result_r <= quot;
                    result_hi_r <= remd;
                end
                default:
                begin
                    result_r <= result_r;
                end
            endcase
        end
    end
    // ****************************************
    // Interrupt request bits
    // ****************************************
    // A write is parked one instruction before the tested copy sees it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ireq_pend_r <= `CSFA_BYTE_RST;
            ireq_pend_v_r <= 1'b0;
        end
        else if (ireq_we)
        begin
            ireq_pend_r <= ireq_wdata;
            ireq_pend_v_r <= 1'b1;
        end
        else if (op_valid)
        begin
            ireq_pend_v_r <= 1'b0;
        end
    end
    // Hardware set wins over a software clear landing in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ireq_r <= `CSFA_BYTE_RST;
        end
        else if (ireq_pend_v_r && op_valid)
        begin
            ireq_r <= ireq_pend_r | ireq_set;
        end
        else
        begin
            ireq_r <= ireq_r | ireq_set;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ireq_view_r <= `CSFA_BYTE_RST;
        end
        else
        begin
            ireq_view_r <= ireq_r;
        end
    end
    // ****************************************
    // Internal clock divider
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_seen_r <= 1'b0;
        end
        else
        begin
            osc_s1_r <= main_osc_input;
            osc_s2_r <= osc_s1_r;
            osc_seen_r <= osc_s2_r;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            speed_r <= CSFA_SPD_MID;
        end
        else
        begin
            speed_r <= high_speed ? CSFA_SPD_HIGH : CSFA_SPD_MID;
        end
    end
    // clk stands in for the oscillator; phi ticks measure instruction cycles
    assign div_lim = (speed_r == CSFA_SPD_HIGH) ? `CSFA_DIV_HIGH : `CSFA_DIV_MID;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_r <= `CSFA_DIV_ZERO;
            phi_tick_r <= 1'b0;
        end
        else if (div_cnt_r >= div_lim - `CSFA_DIV_ONE)
        begin
            div_cnt_r <= `CSFA_DIV_ZERO;
            phi_tick_r <= 1'b1;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + `CSFA_DIV_ONE;
            phi_tick_r <= 1'b0;
        end
    end
endmodule

// *** test/csfa_core_monitor.sv ***
// Assertion checker for the status flag block
`timescale 1ns/1ns
module csfa_core_monitor
    import csfa_pkg::*;
(
    // Clock, reset and issue
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire csfa_op_type op_code,
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic flags_we,
    input wire logic [7:0] ireq_set,
    input wire logic high_speed,
    // Results
    input wire logic [7:0] result_r,
    input wire logic [7:0] result_hi_r,
    input wire logic [7:0] cpu_flags_word,
    input wire logic [7:0] ireq_view_r,
    input wire logic phi_tick_r
);
    // ****
    // Properties
    // ****
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic go;
    assign go = op_valid && !flags_we;
    a_mask_after_reset: assert property ($fell(rst) |-> cpu_flags_word[2])
        else $error("mask flag clear after reset");
    a_dec_digit_ok: assert property (
        go && cpu_flags_word[3] && op_code inside {CSFA_OP_ADD, CSFA_OP_SUB}
        && op_a[3:0] <= 4'h9 && op_b[3:0] <= 4'h9 |=> result_r[3:0] <= 4'h9)
        else $error("decimal digit out of range");
    a_dec_mode_kept: assert property (
        go && cpu_flags_word[3] && op_code inside {CSFA_OP_ADD, CSFA_OP_SUB}
        |=> cpu_flags_word[5:2] == $past(cpu_flags_word[5:2]))
        else $error("decimal op disturbed mode flags");
    a_mul_product: assert property (go && op_code == CSFA_OP_MUL
        |=> {result_hi_r, result_r} == $past(op_a) * $past(op_b))
        else $error("product wrong");
    a_muldiv_flags_kept: assert property (
        go && op_code inside {CSFA_OP_MUL, CSFA_OP_DIV} |=> $stable(cpu_flags_word))
        else $error("status word changed by mul or div");
    // Request bits may only move two edges after an instruction or a hardware set
    a_ireq_late: assert property ($changed(ireq_view_r)
        |-> $past(op_valid, 2) || $past(ireq_set, 2) != 8'h00)
        else $error("request bits visible too early");
    a_phi_high: assert property (high_speed[*3] ##0 phi_tick_r ##1 high_speed
        |-> !phi_tick_r ##1 phi_tick_r)
        else $error("high speed period wrong");
    a_phi_mid: assert property (
        (!high_speed)[*8] ##0 phi_tick_r ##1 (!high_speed)[*7]
        |-> !phi_tick_r ##1 phi_tick_r)
        else $error("middle speed period wrong");
    cover property (go && op_code == CSFA_OP_MUL);
    cover property (go && cpu_flags_word[3] && op_code == CSFA_OP_SUB);
    cover property (phi_tick_r && high_speed);
endmodule

// *** test/tb_csfa_core.sv ***
// Self-checking bench for the status flag block
`timescale 1ns/1ns
module tb_csfa_core;
    import csfa_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    csfa_op_type op_code = CSFA_OP_NONE;
    logic [7:0] op_a = 8'h00;
    logic [7:0] op_b = 8'h00;
    logic flags_we = 1'b0;
    logic [7:0] flags_wdata = 8'h00;
    logic ireq_we = 1'b0;
    logic [7:0] ireq_wdata = 8'h00;
    logic [7:0] ireq_set = 8'h00;
    logic high_speed = 1'b0;
    logic main_osc_input = 1'b0;
    logic [7:0] result_r, result_hi_r, cpu_flags_word, ireq_view_r;
    logic phi_tick_r, osc_seen_r;
    int mismatches = 0;
    int num_checks = 0;
    always #50 clk = ~clk;
    csfa_core csfa_core_i (.clk(clk), .rst(rst), .main_osc_input(main_osc_input),
        .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
        .flags_we(flags_we), .flags_wdata(flags_wdata), .ireq_we(ireq_we),
        .ireq_wdata(ireq_wdata), .ireq_set(ireq_set), .high_speed(high_speed),
        .result_r(result_r), .result_hi_r(result_hi_r), .cpu_flags_word(cpu_flags_word),
        .ireq_view_r(ireq_view_r), .phi_tick_r(phi_tick_r), .osc_seen_r(osc_seen_r));
    // ****
    // Shared tasks
    // ****
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic wflags(input logic [7:0] v);
        @(posedge clk);
        flags_we <= 1'b1;
        flags_wdata <= v;
        @(posedge clk);
        flags_we <= 1'b0;
    endtask
    task automatic op(input csfa_op_type c, input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_a <= a;
        op_b <= b;
        @(posedge clk);
        op_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // Bounded so a stuck divider ends the run instead of hanging it
    task automatic per(input logic [7:0] e);
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (phi_tick_r !== 1'b1 && k < 40);
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (phi_tick_r !== 1'b1 && k < 40);
        chk("phi period", e, k[7:0]);
        if (k >= 40)
            summarize();
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        @(posedge clk);
        #1;
        chk("mask flag", 16'h1, cpu_flags_word[2]);
        per(8'h08);
        wflags(8'h00);
        @(posedge clk);
        #1;
        chk("mask cleared", 16'h0, cpu_flags_word[2]);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("mask after second reset", 16'h1, cpu_flags_word[2]);
        per(8'h08);
    endtask
    task automatic t_arith();
        csfa_op_type oc[4] = '{CSFA_OP_ADD, CSFA_OP_ADD, CSFA_OP_SUB, CSFA_OP_ADD};
        logic [7:0] fw[4] = '{8'h0C, 8'h0C, 8'h0D, 8'h04};
        logic [7:0] a[4] = '{8'h45, 8'h99, 8'h50, 8'h45};
        logic [7:0] b[4] = '{8'h38, 8'h01, 8'h01, 8'h38};
        logic [7:0] r[4] = '{8'h83, 8'h00, 8'h49, 8'h7D};
        logic cy[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            wflags(fw[i]);
            op(oc[i], a[i], b[i]);
            chk("sum", {8'h00, r[i]}, {8'h00, result_r});
            chk("carry", {15'h0, cy[i]}, {15'h0, cpu_flags_word[0]});
            chk("mode flags", {12'h000, fw[i][5:2]}, cpu_flags_word[5:2]);
        end
    endtask
    task automatic t_muldiv();
        logic [7:0] fl;
        for (int i = 0; i < 2; i++)
        begin
            fl = (i == 0) ? 8'h04 : 8'h2D;
            wflags(fl);
            op(CSFA_OP_MUL, 8'h12, 8'h34);
            chk("product", 16'h03A8, {result_hi_r, result_r});
            chk("flags after mul", {8'h00, fl}, cpu_flags_word);
            op(CSFA_OP_DIV, 8'hC8, 8'h07);
            chk("quotient", 16'h041C, {result_hi_r, result_r});
            chk("flags after div", {8'h00, fl}, cpu_flags_word);
        end
        // Divide by zero gives all ones and hands the dividend back as remainder
        op(CSFA_OP_DIV, 8'h5A, 8'h00);
        chk("divide by zero", 16'h5AFF, {result_hi_r, result_r});
        chk("flags after div by zero", {8'h00, fl}, cpu_flags_word);
    endtask
    // A spacer instruction sits between decimal arithmetic and the carry ops
    task automatic t_order();
        wflags(8'h0C);
        op(CSFA_OP_ADD, 8'h99, 8'h01);
        chk("decimal carry", 16'h1, cpu_flags_word[0]);
        op(CSFA_OP_NONE, 8'h00, 8'h00);
        op(CSFA_OP_CLRC, 8'h00, 8'h00);
        chk("carry cleared", 16'h0, cpu_flags_word[0]);
        op(CSFA_OP_SETC, 8'h00, 8'h00);
        chk("carry set", 16'h1, cpu_flags_word[0]);
        chk("mode flags kept", 16'h3, cpu_flags_word[5:2]);
    endtask
    // The oscillator pin reaches its echo three edges after it is driven
    task automatic t_osc();
        @(posedge clk);
        main_osc_input <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("osc not yet seen", 16'h0, osc_seen_r);
        @(posedge clk);
        #1;
        chk("osc seen", 16'h1, osc_seen_r);
        @(posedge clk);
        main_osc_input <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("osc low seen", 16'h0, osc_seen_r);
    endtask
    task automatic t_ireq();
        @(posedge clk);
        ireq_we <= 1'b1;
        ireq_wdata <= 8'h81;
        @(posedge clk);
        ireq_we <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("request early", 16'h0, ireq_view_r);
        op(CSFA_OP_NONE, 8'h00, 8'h00);
        chk("request after instr", 16'h81, ireq_view_r);
        @(posedge clk);
        ireq_set <= 8'h10;
        @(posedge clk);
        ireq_set <= 8'h00;
        @(posedge clk);
        #1;
        chk("request set", 16'h91, ireq_view_r);
    endtask
    task automatic t_speed();
        @(posedge clk);
        high_speed <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        per(8'h02);
        @(posedge clk);
        high_speed <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        per(8'h08);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_arith();
        t_muldiv();
        t_order();
        t_ireq();
        t_osc();
        t_speed();
        summarize();
    end
endmodule
bind csfa_core csfa_core_monitor csfa_core_monitor_i (.clk(clk), .rst(rst),
    .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b), .flags_we(flags_we),
    .ireq_set(ireq_set), .high_speed(high_speed), .result_r(result_r),
    .result_hi_r(result_hi_r), .cpu_flags_word(cpu_flags_word),
    .ireq_view_r(ireq_view_r), .phi_tick_r(phi_tick_r));
